// [core/css_defs.svh]
// Offsets, field positions, reset values and timing counts for the command
// source selector. Assumes a 100 MHz pclk and 32-bit APB data.
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

`define CSS_OFF_CTRL 12'h000
`define CSS_OFF_DECEL 12'h004
`define CSS_OFF_OLRATE 12'h008
`define CSS_OFF_STATUS 12'h00C
`define CSS_OFF_FREQ 12'h010

`define CSS_CTRL_SER_LSB 0
`define CSS_CTRL_FB_LSB 4
`define CSS_CTRL_PERMIT_ASSIGNED 6
`define CSS_CTRL_AUTO_DECEL 7
`define CSS_CTRL_RUN_TERMINAL 8
`define CSS_CTRL_FREQ_TWO 9
`define CSS_CTRL_WIDTH 10

`define CSS_CTRL_RESET 10'h000
`define CSS_DECEL_RESET 16'h0064
`define CSS_OLRATE_RESET 17'h1_863C

`define CSS_SER_MODE_MAX 4'h8
`define CSS_OLRATE_OFF 17'h1_863C
`define CSS_OLRATE_MAX 17'h0_2710
`define CSS_MAX_FREQ 16'h1770

`define CSS_CLK_PERIOD_NS 10
`define CSS_TICK_US 10
`define CSS_TICK_CYCLES (`CSS_TICK_US * 1000 / `CSS_CLK_PERIOD_NS)
`define CSS_DECEL_UNIT_US 100000
`define CSS_TICKS_PER_DECEL_UNIT (`CSS_DECEL_UNIT_US / `CSS_TICK_US)
`define CSS_TICKS_PER_SEC (1000000 / `CSS_TICK_US)
`define CSS_AUTO_DECEL_FACTOR 3

`endif

// [core/css_pkg.sv]
// Types shared by the command source selector.
// Assumes css_defs.svh supplies the numeric constants.
package css_pkg;

   typedef enum logic [1:0] {
      CSS_SRC_LOCAL = 2'b00,
      CSS_SRC_SERIAL = 2'b01,
      CSS_SRC_OPTION = 2'b10,
      CSS_SRC_FIELDBUS = 2'b11
   } css_src_t;

   typedef enum logic [2:0] {
      CSS_RS_STEADY = 3'b000,
      CSS_RS_UP = 3'b001,
      CSS_RS_DOWN = 3'b010,
      CSS_RS_HOLD = 3'b011,
      CSS_RS_OVERLOAD = 3'b100
   } css_ramp_t;

   // One command from a remote source: run request and frequency in 0.01 Hz.
   typedef struct packed {
      logic run;
      logic [15:0] freq;
   } css_cmd_t;

endpackage

// [core/css_command_select.sv]
// Command source selector with output frequency ramp, automatic
// deceleration and overload prevention, reached over APB.
// Assumes remote command structs come from logic on pclk; digital pins
// (terminals, permit, DC link and overload warnings) are asynchronous.
`timescale 1ns/1ps
`include "css_defs.svh"

// How it works
// R1: One mode field picks serial-link sources, another picks field-bus sources.
// R2: Serial mode 0: local frequency and local run.
// R3: Serial mode 1: serial port frequency, local run.
// R4: Serial mode 2: local frequency, serial port run.
// R5: Serial mode 3: serial port frequency and run.
// R6: Serial mode 4: option card frequency, local run.
// R7: Serial mode 5: option card frequency, serial port run.
// R8: Serial mode 6: local frequency, option card run.
// R9: Serial mode 7: serial port frequency, option card run.
// R10: Serial mode 8: option card frequency and run.
// R11: Field-bus mode 0 keeps both serial-mode choices.
// R12: Field-bus mode 1: field-bus frequency, serial-mode run choice.
// R13: Field-bus mode 2: field-bus run, serial-mode frequency choice.
// R14: Field-bus mode 3: field-bus frequency and run regardless of serial mode.
// R15: Assigned permit inactive forces local sources; active applies both modes.
// R16: Local run is keypad or terminal; local frequency is setting or multistep.
// R17: Automatic deceleration holds frequency while DC link voltage is high.
// R18: Automatic deceleration lasting three decel times without falling is cancelled.
// R19: Overload warning lowers output frequency before a trip.
// R20: Overload rate zero uses the first deceleration time.
// R21: Overload rate 0.01 to 100.0 Hz/s lowers frequency at that rate.
// R22: Overload rate 999 disables overload prevention.
module css_command_select (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Local command sources
   input wire logic [15:0] local_freq_setting_one,
   input wire logic [15:0] local_freq_setting_two,
   input wire logic [15:0] multistep_freq,
   input wire logic multistep_active,
   input wire logic keypad_run,
   // Asynchronous digital pins
   input wire logic terminal_run,
   input wire logic remote_command_permit,
   input wire logic dc_link_high,
   input wire logic overload_warn,
   // Remote command sources
   input wire css_pkg::css_cmd_t serial_cmd,
   input wire css_pkg::css_cmd_t option_cmd,
   input wire css_pkg::css_cmd_t fieldbus_cmd,
   // Drive outputs
   output logic [15:0] freq_out,
   output logic run_out,
   output css_pkg::css_src_t freq_src,
   output css_pkg::css_src_t run_src
);

   // Pin synchronisers, one pair of flops per pin.
   localparam int NPIN = 4;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta_q;
   logic [NPIN-1:0] pin_q;
   assign pin_raw = {overload_warn, dc_link_high, remote_command_permit,
                     terminal_run};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_meta_q[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
            end else begin
               pin_meta_q[gi] <= pin_raw[gi];
               pin_q[gi] <= pin_meta_q[gi];
            end
         end
      end
   endgenerate

   logic term_run_s;
   logic permit_s;
   logic dc_high_s;
   logic ol_warn_s;
   assign term_run_s = pin_q[0];
   assign permit_s = pin_q[1];
   assign dc_high_s = pin_q[2];
   assign ol_warn_s = pin_q[3];

   // Software registers.
   logic [`CSS_CTRL_WIDTH-1:0] ctrl_q;
   logic [15:0] decel_time_one_q;
   logic [16:0] overload_prevent_rate_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   logic [3:0] serial_source_mode;
   logic [1:0] fieldbus_source_mode;
   logic permit_assigned;
   logic auto_decel_select;
   logic local_run_source;
   logic freq_two_sel;
   assign serial_source_mode = ctrl_q[`CSS_CTRL_SER_LSB +: 4];
   assign fieldbus_source_mode = ctrl_q[`CSS_CTRL_FB_LSB +: 2];
   assign permit_assigned = ctrl_q[`CSS_CTRL_PERMIT_ASSIGNED];
   assign auto_decel_select = ctrl_q[`CSS_CTRL_AUTO_DECEL];
   assign local_run_source = ctrl_q[`CSS_CTRL_RUN_TERMINAL];
   assign freq_two_sel = ctrl_q[`CSS_CTRL_FREQ_TWO];

   // Source selection.
   logic [3:0] sm;
   logic ser_freq_serial;
   logic ser_freq_option;
   logic ser_run_serial;
   logic ser_run_option;
   css_pkg::css_src_t ser_freq_src;
   css_pkg::css_src_t ser_run_src;
   css_pkg::css_src_t mode_freq_src;
   css_pkg::css_src_t mode_run_src;
   logic remote_ok;
   assign sm = serial_source_mode;
   assign ser_freq_serial = (sm == 4'h1) || (sm == 4'h3) || (sm == 4'h7); // R3 R5 R9
   assign ser_freq_option = (sm == 4'h4) || (sm == 4'h5) || (sm == 4'h8); // R6 R7 R10
   assign ser_run_serial = (sm == 4'h2) || (sm == 4'h3) || (sm == 4'h5); // R4 R5 R7
   assign ser_run_option = (sm == 4'h6) || (sm == 4'h7) || (sm == 4'h8); // R8 R9 R10
   // Modes 0 and codes above 8 fall back to local sources.
   assign ser_freq_src = ser_freq_serial ? css_pkg::CSS_SRC_SERIAL :
                         ser_freq_option ? css_pkg::CSS_SRC_OPTION :
                         css_pkg::CSS_SRC_LOCAL; // R1 R2
   assign ser_run_src = ser_run_serial ? css_pkg::CSS_SRC_SERIAL :
                        ser_run_option ? css_pkg::CSS_SRC_OPTION :
                        css_pkg::CSS_SRC_LOCAL; // R1 R2
   assign mode_freq_src = fieldbus_source_mode[0] ?
                          css_pkg::CSS_SRC_FIELDBUS : ser_freq_src; // R11 R12 R14
   assign mode_run_src = fieldbus_source_mode[1] ?
                         css_pkg::CSS_SRC_FIELDBUS : ser_run_src; // R11 R13 R14
   // An unassigned permit leaves the modes in force.
   assign remote_ok = !permit_assigned || permit_s; // R15

   css_pkg::css_src_t freq_sel_src;
   css_pkg::css_src_t run_sel_src;
   assign freq_sel_src = remote_ok ? mode_freq_src :
                         css_pkg::CSS_SRC_LOCAL; // R15
   assign run_sel_src = remote_ok ? mode_run_src :
                        css_pkg::CSS_SRC_LOCAL; // R15

   logic [15:0] local_freq;
   logic local_run;
   assign local_freq = multistep_active ? multistep_freq :
                       freq_two_sel ? local_freq_setting_two :
                       local_freq_setting_one; // R16
   assign local_run = local_run_source ? term_run_s : keypad_run; // R16

   logic [15:0] sel_freq;
   logic sel_run;
   assign sel_freq = (freq_sel_src == css_pkg::CSS_SRC_SERIAL) ?
                     serial_cmd.freq :
                     (freq_sel_src == css_pkg::CSS_SRC_OPTION) ?
                     option_cmd.freq :
                     (freq_sel_src == css_pkg::CSS_SRC_FIELDBUS) ?
                     fieldbus_cmd.freq : local_freq;
   assign sel_run = (run_sel_src == css_pkg::CSS_SRC_SERIAL) ?
                    serial_cmd.run :
                    (run_sel_src == css_pkg::CSS_SRC_OPTION) ?
                    option_cmd.run :
                    (run_sel_src == css_pkg::CSS_SRC_FIELDBUS) ?
                    fieldbus_cmd.run : local_run;

   // Ramp timebase: one enable pulse every 10 us.
   localparam logic [9:0] TICK_LAST = 10'(`CSS_TICK_CYCLES - 1);
   logic [9:0] tick_cnt_q;
   logic tick;
   assign tick = (tick_cnt_q == TICK_LAST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 10'h000;
      end else begin
         tick_cnt_q <= tick ? 10'h000 : tick_cnt_q + 10'h001;
      end
   end

   // Ramp engine.
   logic [15:0] freq_q;
   logic [31:0] acc_q;
   logic [31:0] hold_cnt_q;
   logic cancel_q;

   logic [15:0] target;
   logic ol_enabled;
   logic ol_active;
   logic going_down;
   logic going_up;
   logic auto_hold;
   css_pkg::css_ramp_t ramp;
   assign target = !sel_run ? 16'h0000 :
                   (sel_freq > `CSS_MAX_FREQ) ? `CSS_MAX_FREQ : sel_freq;
   assign ol_enabled = (overload_prevent_rate_q != `CSS_OLRATE_OFF); // R22
   assign ol_active = ol_enabled && ol_warn_s && (freq_q != 16'h0000); // R19
   assign going_down = (freq_q > target);
   assign going_up = (freq_q < target);
   // Auto deceleration only acts on a commanded slowdown, not on overload.
   assign auto_hold = going_down && auto_decel_select && dc_high_s &&
                      !cancel_q; // R17
   assign ramp = ol_active ? css_pkg::CSS_RS_OVERLOAD :
                 auto_hold ? css_pkg::CSS_RS_HOLD :
                 going_down ? css_pkg::CSS_RS_DOWN :
                 going_up ? css_pkg::CSS_RS_UP : css_pkg::CSS_RS_STEADY;

   // Step and threshold of the rate accumulator. The frequency moves at most
   // one count per tick, which caps a ramp at 1000 Hz/s.
   logic [31:0] decel_thresh;
   logic [31:0] auto_limit;
   logic [31:0] ol_step;
   assign decel_thresh = 32'(decel_time_one_q) *
                         32'(`CSS_TICKS_PER_DECEL_UNIT);
   assign auto_limit = 32'(`CSS_AUTO_DECEL_FACTOR) * decel_thresh; // R18
   assign ol_step = (overload_prevent_rate_q > `CSS_OLRATE_MAX) ?
                    32'(`CSS_OLRATE_MAX) : 32'(overload_prevent_rate_q);

   logic [31:0] step;
   logic [31:0] thresh;
   always_comb begin
      step = 32'(`CSS_MAX_FREQ);
      thresh = decel_thresh;
      unique case (ramp)
         css_pkg::CSS_RS_OVERLOAD: begin
            if (overload_prevent_rate_q != 17'h0_0000) begin
               step = ol_step; // R21
               thresh = 32'(`CSS_TICKS_PER_SEC); // R21
            end
         end
         css_pkg::CSS_RS_STEADY, css_pkg::CSS_RS_UP, css_pkg::CSS_RS_DOWN,
         css_pkg::CSS_RS_HOLD: begin
         end
         default: begin
         end
      endcase
   end

   logic [31:0] acc_sum;
   logic move;
   logic moving;
   assign acc_sum = acc_q + step;
   assign moving = (ramp == css_pkg::CSS_RS_UP) ||
                   (ramp == css_pkg::CSS_RS_DOWN) ||
                   (ramp == css_pkg::CSS_RS_OVERLOAD);
   assign move = tick && moving && (acc_sum >= thresh); // R20

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 32'h0000_0000;
      end else if (!moving) begin
         acc_q <= 32'h0000_0000;
      end else if (tick) begin
         acc_q <= move ? acc_sum - thresh : acc_sum;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_q <= 16'h0000;
      end else if (move) begin
         if (ramp == css_pkg::CSS_RS_UP) begin
            freq_q <= freq_q + 16'h0001;
         end else begin
            freq_q <= freq_q - 16'h0001; // R19
         end
      end
   end

   // Time spent holding without a fall; reset by any fall or end of slowdown.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_q <= 32'h0000_0000;
      end else if (!going_down || move) begin
         hold_cnt_q <= 32'h0000_0000;
      end else if (tick && ramp == css_pkg::CSS_RS_HOLD &&
                   hold_cnt_q != 32'hFFFF_FFFF) begin
         hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
      end
   end

   // Cancellation lasts until the slowdown completes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cancel_q <= 1'b0;
      end else if (!going_down) begin
         cancel_q <= 1'b0;
      end else if (ramp == css_pkg::CSS_RS_HOLD &&
                   hold_cnt_q >= auto_limit) begin
         cancel_q <= 1'b1; // R18
      end
   end

   // Registered drive outputs.
   logic run_q;
   css_pkg::css_src_t freq_src_q;
   css_pkg::css_src_t run_src_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         freq_src_q <= css_pkg::CSS_SRC_LOCAL;
         run_src_q <= css_pkg::CSS_SRC_LOCAL;
      end else begin
         run_q <= sel_run || (freq_q != 16'h0000);
         freq_src_q <= freq_sel_src;
         run_src_q <= run_sel_src;
      end
   end
   assign freq_out = freq_q;
   assign run_out = run_q;
   assign freq_src = freq_src_q;
   assign run_src = run_src_q;

   // APB decode. The slave never inserts wait states.
   logic setup;
   logic hit_ctrl;
   logic hit_decel;
   logic hit_olrate;
   logic hit_status;
   logic hit_freq;
   logic mapped;
   logic wr_en;
   assign setup = psel && !penable;
   assign hit_ctrl = (paddr == `CSS_OFF_CTRL);
   assign hit_decel = (paddr == `CSS_OFF_DECEL);
   assign hit_olrate = (paddr == `CSS_OFF_OLRATE);
   assign hit_status = (paddr == `CSS_OFF_STATUS);
   assign hit_freq = (paddr == `CSS_OFF_FREQ);
   assign mapped = hit_ctrl || hit_decel || hit_olrate || hit_status ||
                   hit_freq;
   assign wr_en = psel && penable && pwrite;

   logic [31:0] status_word;
   assign status_word = {20'h0_0000, cancel_q, permit_s, ol_active,
                         auto_hold, run_q, 1'b0, ramp == css_pkg::CSS_RS_HOLD,
                         1'b0, run_sel_src, freq_sel_src};

   logic [31:0] rd_word;
   assign rd_word = hit_ctrl ? 32'(ctrl_q) :
                    hit_decel ? 32'(decel_time_one_q) :
                    hit_olrate ? 32'(overload_prevent_rate_q) :
                    hit_status ? status_word :
                    hit_freq ? 32'(freq_q) : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CSS_CTRL_RESET;
         decel_time_one_q <= `CSS_DECEL_RESET;
         overload_prevent_rate_q <= `CSS_OLRATE_RESET;
      end else if (wr_en) begin
         if (hit_ctrl) begin
            ctrl_q <= pwdata[`CSS_CTRL_WIDTH-1:0]; // R1
         end
         if (hit_decel) begin
            decel_time_one_q <= pwdata[15:0];
         end
         if (hit_olrate) begin
            overload_prevent_rate_q <= pwdata[16:0];
         end
      end
   end

   // Read data and error are captured in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr_q <= !mapped || (pwrite && (hit_status || hit_freq));
      end
   end
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = pslverr_q;

endmodule

// [test/css_remote_model.sv]
// Model of the remote hosts that feed the three command buses.
// Assumes the bench loads one host at a time, synchronous to pclk.
`timescale 1ns/1ps
module css_remote_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Load request from the bench
   input wire logic load,
   input wire css_pkg::css_src_t which,
   input wire css_pkg::css_cmd_t cmd,
   // Command buses
   output css_pkg::css_cmd_t serial_cmd,
   output css_pkg::css_cmd_t option_cmd,
   output css_pkg::css_cmd_t fieldbus_cmd
);
   // A host keeps its last command until it sends another one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_cmd <= '0;
         option_cmd <= '0;
         fieldbus_cmd <= '0;
      end else if (load) begin
         if (which == css_pkg::CSS_SRC_SERIAL)
            serial_cmd <= cmd;
         if (which == css_pkg::CSS_SRC_OPTION)
            option_cmd <= cmd;
         if (which == css_pkg::CSS_SRC_FIELDBUS)
            fieldbus_cmd <= cmd;
      end
   end
endmodule

// [test/css_command_select_monitor.sv]
// Concurrent checks on the command source selector ports.
// Assumes CTRL at offset 0 and no APB wait states.
`timescale 1ns/1ps
module css_command_select_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin and outputs
   input wire logic remote_command_permit,
   input wire logic [15:0] freq_out,
   input wire css_pkg::css_src_t freq_src,
   input wire css_pkg::css_src_t run_src
);
   logic [9:0] ctrl_q;
   logic [2:0] quiet_q;
   logic perm_q;
   wire acc = psel && penable && pready;
   wire mapped = paddr <= 12'h010 && paddr[1:0] == 2'h0;
   wire ctrl_wr = acc && pwrite && paddr == 12'h000;
   wire active = !ctrl_q[6] || perm_q;
   wire [3:0] s = ctrl_q[3:0];
   wire [1:0] ser_f = (s == 4'h1 || s == 4'h3 || s == 4'h7) ? 2'h1 :
      (s == 4'h4 || s == 4'h5 || s == 4'h8) ? 2'h2 : 2'h0;
   wire [1:0] ser_r = (s == 4'h2 || s == 4'h3 || s == 4'h5) ? 2'h1 :
      (s == 4'h6 || s == 4'h7 || s == 4'h8) ? 2'h2 : 2'h0;
   wire [1:0] exp_f = !active ? 2'h0 : ctrl_q[4] ? 2'h3 : ser_f;
   wire [1:0] exp_r = !active ? 2'h0 : ctrl_q[5] ? 2'h3 : ser_r;
   // Sources are only judged once the permit pin has crossed its syncers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 10'h000;
         quiet_q <= 3'h0;
         perm_q <= 1'b0;
      end else begin
         perm_q <= remote_command_permit;
         if (ctrl_wr)
            ctrl_q <= pwdata[9:0];
         if (ctrl_wr || remote_command_permit != perm_q)
            quiet_q <= 3'h0;
         else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_always: assert property (pready)
      else $error("pready low");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   a_unmapped_zero: assert property (acc && !pwrite && !mapped
      |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_ro_write: assert property (acc && pwrite && paddr >= 12'h00C
      && paddr <= 12'h010 |-> pslverr) else $error("read-only write accepted");
   a_freq_source: assert property (quiet_q >= 3'h5 |-> freq_src == exp_f)
      else $error("frequency source wrong");
   a_run_source: assert property (quiet_q >= 3'h5 |-> run_src == exp_r)
      else $error("run source wrong");
   a_freq_ceiling: assert property (freq_out <= 16'h1770)
      else $error("frequency above ceiling");
   a_freq_step: assert property ($changed(freq_out) |->
      freq_out - $past(freq_out) == 16'h0001 ||
      $past(freq_out) - freq_out == 16'h0001) else $error("step too large");
   a_step_spacing: assert property ($changed(freq_out)
      |=> $stable(freq_out) [*8]) else $error("steps too close");
   c_ctrl_write: cover property (ctrl_wr);
   c_error_resp: cover property (acc && pslverr);
   c_freq_fall: cover property (freq_out < $past(freq_out));
endmodule

bind css_command_select css_command_select_monitor css_command_select_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .remote_command_permit(remote_command_permit), .freq_out(freq_out),
   .freq_src(freq_src), .run_src(run_src));

// [test/css_command_select_test.sv]
// Self-checking bench for the command source selector and remote hosts.
// Assumes the selector answers APB with no wait states.
`timescale 1ns/1ps
module css_command_select_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic kpad, term, permit, dclink, olwarn, run_out, ld, msa;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] freq_out, f0, lf2;
   css_pkg::css_src_t freq_src, run_src, which;
   css_pkg::css_cmd_t cmd, scmd, ocmd, fcmd;
   int fails, compares, cyc;

   css_command_select css_command_select_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .local_freq_setting_one(16'h0000), .local_freq_setting_two(lf2),
      .multistep_freq(16'h0000), .multistep_active(msa),
      .keypad_run(kpad), .terminal_run(term),
      .remote_command_permit(permit), .dc_link_high(dclink),
      .overload_warn(olwarn), .serial_cmd(scmd), .option_cmd(ocmd),
      .fieldbus_cmd(fcmd), .freq_out(freq_out), .run_out(run_out),
      .freq_src(freq_src), .run_src(run_src));

   css_remote_model css_remote_model_i (
      .pclk(pclk), .presetn(presetn), .load(ld), .which(which), .cmd(cmd),
      .serial_cmd(scmd), .option_cmd(ocmd), .fieldbus_cmd(fcmd));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // A hang here would stall every check, so cycles are capped.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 98000) begin
         fails++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                        input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
      chk({31'h0000_0000, err}, {31'h0000_0000, ee});
   endtask

   task automatic send(input css_pkg::css_src_t w, input logic r,
                       input logic [15:0] f);
      which <= w;
      cmd <= '{run: r, freq: f};
      ld <= 1'b1;
      @(posedge pclk);
      ld <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   task automatic ctrl(input logic [31:0] v);
      apb(1'b1, 12'h000, v);
      repeat (6) @(posedge pclk);
   endtask

   function automatic logic [3:0] exp_src(input int s, input int fb);
      logic [1:0] f, r;
      f = (s == 1 || s == 3 || s == 7) ? 2'h1 :
         (s == 4 || s == 5 || s == 8) ? 2'h2 : 2'h0;
      r = (s == 2 || s == 3 || s == 5) ? 2'h1 :
         (s == 6 || s == 7 || s == 8) ? 2'h2 : 2'h0;
      if (fb[0])
         f = 2'h3;
      if (fb[1])
         r = 2'h3;
      return {r, f};
   endfunction

   initial begin
      {psel, penable, pwrite, kpad, term, dclink, olwarn, ld, msa} = 9'h000;
      lf2 = 16'h0003;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      permit = 1'b1;
      which = css_pkg::CSS_SRC_LOCAL;
      cmd = '0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(12'h000, 32'h0000_0000, 1'b0);
      rdchk(12'h004, 32'h0000_0064, 1'b0);
      rdchk(12'h008, 32'h0001_863C, 1'b0);
      rdchk(12'h014, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h00C, 32'h0000_FFFF);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      apb(1'b1, 12'h004, 32'h0000_0001);
      rdchk(12'h004, 32'h0000_0001, 1'b0);
      for (int s = 0; s < 9; s++) begin
         for (int fb = 0; fb < 4; fb++) begin
            ctrl(32'h0000_0040 | 32'(fb * 16 + s));
            chk({28'h000_0000, run_src, freq_src}, 32'(exp_src(s, fb)));
         end
      end
      permit <= 1'b0;
      ctrl(32'h0000_0073);
      chk({28'h000_0000, run_src, freq_src}, 32'h0000_0000);
      permit <= 1'b1;
      kpad <= 1'b1;
      ctrl(32'h0000_0100);
      chk({31'h0000_0000, run_out}, 32'h0000_0000);
      term <= 1'b1;
      ctrl(32'h0000_0100);
      chk({31'h0000_0000, run_out}, 32'h0000_0001);
      term <= 1'b0;
      ctrl(32'h0000_0000);
      chk({31'h0000_0000, run_out}, 32'h0000_0001);
      ctrl(32'h0000_0200);
      repeat (6000) @(posedge pclk);
      chk({16'h0000, freq_out}, 32'h0000_0003);
      msa <= 1'b1;
      repeat (6000) @(posedge pclk);
      chk({16'h0000, freq_out}, 32'h0000_0000);
      kpad <= 1'b0;
      send(css_pkg::CSS_SRC_SERIAL, 1'b1, 16'h0000);
      ctrl(32'h0000_0002);
      chk({31'h0000_0000, run_out}, 32'h0000_0001);
      ctrl(32'h0000_0006);
      chk({31'h0000_0000, run_out}, 32'h0000_0000);
      send(css_pkg::CSS_SRC_FIELDBUS, 1'b1, 16'h0000);
      ctrl(32'h0000_0026);
      chk({31'h0000_0000, run_out}, 32'h0000_0001);
      send(css_pkg::CSS_SRC_SERIAL, 1'b0, 16'h0064);
      kpad <= 1'b1;
      ctrl(32'h0000_0001);
      repeat (20000) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(rd[15:0] >= 16'h000A && rd[15:0] <= 16'h000C), 32'h1);
      f0 = rd[15:0];
      olwarn <= 1'b1;
      repeat (10000) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(rd[15:0] > f0), 32'h0000_0001);
      f0 = rd[15:0];
      apb(1'b1, 12'h008, 32'h0000_2710);
      repeat (30000) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(rd[15:0] < f0 && rd[15:0] + 16'h4 >= f0), 32'h1);
      f0 = rd[15:0];
      apb(1'b1, 12'h008, 32'h0000_0000);
      repeat (10000) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(f0 - rd[15:0] >= 16'h5 && f0 - rd[15:0] <= 16'h7), 32'h1);
      olwarn <= 1'b0;
      dclink <= 1'b1;
      kpad <= 1'b0;
      ctrl(32'h0000_0081);
      apb(1'b0, 12'h010, 32'h0000_0000);
      f0 = rd[15:0];
      repeat (5000) @(posedge pclk);
      rdchk(12'h010, {16'h0000, f0}, 1'b0);
      dclink <= 1'b0;
      repeat (5000) @(posedge pclk);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(rd[15:0] < f0), 32'h0000_0001);
      // A zero decel time makes three decel times elapse at once.
      dclink <= 1'b1;
      apb(1'b1, 12'h004, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk({31'h0000_0000, rd[11]}, 32'h0000_0001);
      results();
   end
endmodule
